/* File: src/mihd_consts.svh */
// Constants for the microphone insert and hook detector
// Assumes inclusion by bare name from mihd_qual, mihd_top and the bench files
`ifndef MIHD_CONSTS_SVH
`define MIHD_CONSTS_SVH
// Register offsets
`define MIHD_CTRL_OFS     8'h00
`define MIHD_STAT_OFS     8'h04
`define MIHD_MASK_OFS     8'h08
`define MIHD_LIVE_OFS     8'h0c
// Field positions
`define MIHD_MIC_BIT      0
`define MIHD_HOOK_BIT     1
`define MIHD_GPIO_SEL_BIT 2
// Reset values
`define MIHD_CTRL_RST     3'h0
`define MIHD_MASK_RST     2'h0
// Qualification counts in samples
`define MIHD_HOOK_SAMPLES 10
`define MIHD_MIC_SAMPLES  10
`endif

/* File: src/mihd_pkg.sv */
// Types for the microphone insert and hook detector
// Assumes nothing beyond a SystemVerilog compiler
package mihd_pkg;
	typedef logic [1:0] mihd_flags_t;
endpackage : mihd_pkg

/* File: src/mihd_qual_if.sv */
// Qualifier interface: one raw condition in, steady state and change pulse out
// Assumes one clock shared with the top
`timescale 1ns/1ns
interface mihd_qual_if;
	logic raw;
	logic steady;
	logic change;
	modport top (output raw, input steady, change);
	modport qual (input raw, output steady, change);
endinterface : mihd_qual_if

/* File: src/mihd_qual.sv */
// Consecutive-sample qualifier for one detect condition
// Assumes a one-cycle sample enable on core_clk
`timescale 1ns/1ns
`include "mihd_consts.svh"
module mihd_qual #(
	parameter int N = 10
) (
	input  wire logic   core_clk,
	input  wire logic   srst,
	input  wire logic   sample_en,
	mihd_qual_if.qual   q
);
	logic [4:0] cnt_r;
	logic       steady_r;
	logic       change_r;

	// Count qualifying samples up to N and hold, so a lasting condition fires once
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt_r <= 5'h00;
		end else if (sample_en) begin
			if (!q.raw)
				cnt_r <= 5'h00;
			else if (cnt_r != 5'(N))
				cnt_r <= cnt_r + 5'h01;
		end
	end

	// Change after N consecutive qualifying samples
	always_ff @(posedge core_clk) begin
		if (srst) begin
			change_r <= 1'b0;
			steady_r <= 1'b0;
		end else begin
			change_r <= sample_en && q.raw && cnt_r == 5'(N - 1);
			if (sample_en && q.raw && cnt_r == 5'(N - 1))
				steady_r <= ~steady_r;
		end
	end

	assign q.steady = steady_r;
	assign q.change = change_r;
endmodule : mihd_qual

/* File: src/mihd_top.sv */
// Microphone insert and hook-switch detector with polled flags
// Assumes comparator outputs arrive asynchronously; register port on core_clk
`timescale 1ns/1ns
`include "mihd_consts.svh"
module mihd_top #(
	parameter int SAMPLE_DIV  = 100,
	parameter int HOOK_SAMPLES = `MIHD_HOOK_SAMPLES,
	parameter int MIC_SAMPLES  = `MIHD_MIC_SAMPLES
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        mic_cmp_in,
	input  wire logic        hook_cmp_in,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq,
	output logic             detect_pin
);
	logic [2:0]           mic_sync_r;
	logic [2:0]           hook_sync_r;
	logic                 mic_lvl_r;
	logic                 hook_lvl_r;
	logic [2:0]           ctrl_r;
	mihd_pkg::mihd_flags_t stat_r;
	mihd_pkg::mihd_flags_t mask_r;
	logic [15:0]          div_r;
	logic                 sample_en;
	logic                 detect_pin_r;
	logic [7:0]           hook_run_r;
	mihd_qual_if          mic_q ();
	mihd_qual_if          hook_q ();

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Write strobe aimed at one register offset
	function automatic logic wr_hit(
		input logic       wr,
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		return wr && addr == ofs;
	endfunction : wr_hit

	// ----------------------------------------------------------------
	// Input synchronisers and sample divider
	// ----------------------------------------------------------------
	// Three stages; level accepted once stages two and three agree
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mic_sync_r  <= 3'h0;
			hook_sync_r <= 3'h0;
			mic_lvl_r   <= 1'b0;
			hook_lvl_r  <= 1'b0;
		end else begin
			mic_sync_r  <= {mic_sync_r[1:0], mic_cmp_in};
			hook_sync_r <= {hook_sync_r[1:0], hook_cmp_in};
			if (mic_sync_r[2] == mic_sync_r[1])
				mic_lvl_r <= mic_sync_r[2];
			if (hook_sync_r[2] == hook_sync_r[1])
				hook_lvl_r <= hook_sync_r[2];
		end
	end

	// Sample strobe every SAMPLE_DIV cycles
	always_ff @(posedge core_clk) begin
		if (srst || div_r == 16'(SAMPLE_DIV - 1))
			div_r <= 16'h0000;
		else
			div_r <= div_r + 16'h0001;
	end
	assign sample_en = (div_r == 16'(SAMPLE_DIV - 1));

	// ----------------------------------------------------------------
	// Qualification
	// ----------------------------------------------------------------
	// Raw condition is the comparison flipped by its polarity bit
	assign mic_q.raw  = mic_lvl_r ^ ctrl_r[`MIHD_MIC_BIT];
	assign hook_q.raw = hook_lvl_r ^ ctrl_r[`MIHD_HOOK_BIT];

	mihd_qual #(.N(MIC_SAMPLES)) u_mic_qual (
		.core_clk  (core_clk),
		.srst      (srst),
		.sample_en (sample_en),
		.q         (mic_q)
	);
	mihd_qual #(.N(HOOK_SAMPLES)) u_hook_qual (
		.core_clk  (core_clk),
		.srst      (srst),
		.sample_en (sample_en),
		.q         (hook_q)
	);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Control: polarities and detect pin source, written by host
	always_ff @(posedge core_clk) begin
		if (srst)
			ctrl_r <= `MIHD_CTRL_RST;
		else if (wr_hit(reg_wr, reg_addr, `MIHD_CTRL_OFS))
			ctrl_r <= reg_wdata[2:0];
	end

	// Mask register
	always_ff @(posedge core_clk) begin
		if (srst)
			mask_r <= `MIHD_MASK_RST;
		else if (wr_hit(reg_wr, reg_addr, `MIHD_MASK_OFS))
			mask_r <= reg_wdata[1:0];
	end

	// Sticky flags; write one clears, a new event wins over the clear
	always_ff @(posedge core_clk) begin
		if (srst)
			stat_r <= 2'h0;
		else
			stat_r <= (stat_r & ~(wr_hit(reg_wr, reg_addr, `MIHD_STAT_OFS) ?
				reg_wdata[1:0] : 2'h0)) | {hook_q.change, mic_q.change};
	end

	// Read data one cycle after strobe
	always_ff @(posedge core_clk) begin
		if (srst || !reg_rd)
			reg_rdata <= 32'h0000_0000;
		else if (reg_addr == `MIHD_CTRL_OFS)
			reg_rdata <= {29'h0, ctrl_r};
		else if (reg_addr == `MIHD_STAT_OFS)
			reg_rdata <= {30'h0, stat_r};
		else if (reg_addr == `MIHD_MASK_OFS)
			reg_rdata <= {30'h0, mask_r};
		else if (reg_addr == `MIHD_LIVE_OFS)
			reg_rdata <= {30'h0, hook_q.steady, mic_q.steady};
		else
			reg_rdata <= 32'h0000_0000;
	end

	assign irq = |(stat_r & mask_r);

	// Detect pin: qualified steady state of the selected condition
	always_ff @(posedge core_clk) begin
		if (srst)
			detect_pin_r <= 1'b0;
		else
			detect_pin_r <= ctrl_r[`MIHD_GPIO_SEL_BIT] ? hook_q.steady : mic_q.steady;
	end
	assign detect_pin = detect_pin_r;

	// ----------------------------------------------------------------
	// Check helpers
	// ----------------------------------------------------------------
	// Consecutive qualifying hook samples, counted apart from the qualifier
	always_ff @(posedge core_clk) begin
		if (srst || (sample_en && !hook_q.raw))
			hook_run_r <= 8'h00;
		else if (sample_en && hook_run_r != 8'hff)
			hook_run_r <= hook_run_r + 8'h01;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	flag_sticky_a: assert property (@(posedge core_clk) disable iff (srst)
		stat_r[0] && !(reg_wr && reg_addr == `MIHD_STAT_OFS && reg_wdata[0]) |=> stat_r[0])
		else $error("mic flag dropped without clear");
	hook_latch_a: assert property (@(posedge core_clk) disable iff (srst)
		hook_q.change |=> stat_r[1])
		else $error("hook change not latched");
	hook_cause_a: assert property (@(posedge core_clk) disable iff (srst)
		$rose(stat_r[1]) |-> $past(hook_q.change))
		else $error("hook flag without change");
	pin_follow_a: assert property (@(posedge core_clk) disable iff (srst)
		!ctrl_r[2] && $stable(ctrl_r) |=> detect_pin == $past(mic_q.steady))
		else $error("detect pin not steady state");
	pin_delay_a: assert property (@(posedge core_clk) disable iff (srst)
		$changed(mic_q.steady) |-> mic_q.change)
		else $error("pin changed without qualification");
	miss_restart_a: assert property (@(posedge core_clk) disable iff (srst)
		sample_en && !hook_q.raw |=> u_hook_qual.cnt_r == 5'h00)
		else $error("miss did not restart count");
	irq_mask_a: assert property (@(posedge core_clk) disable iff (srst)
		irq == |(stat_r & mask_r))
		else $error("irq mismatch");
	read_time_a: assert property (@(posedge core_clk) disable iff (srst)
		reg_rd && reg_addr == `MIHD_STAT_OFS && !hook_q.change && !mic_q.change &&
		!reg_wr |=> reg_rdata[1:0] == $past(stat_r))
		else $error("status read wrong");
	change_spacing_a: assert property (@(posedge core_clk) disable iff (srst)
		hook_q.change |=> !hook_q.change [*8])
		else $error("hook changes too close");
	hook_run_a: assert property (@(posedge core_clk) disable iff (srst)
		hook_q.change |-> hook_run_r >= 8'(HOOK_SAMPLES))
		else $error("hook change before enough samples");
	mic_latch_a: assert property (@(posedge core_clk) disable iff (srst)
		mic_q.change |=> stat_r[0])
		else $error("mic change not latched");
	flag_clear_a: assert property (@(posedge core_clk) disable iff (srst)
		wr_hit(reg_wr, reg_addr, `MIHD_STAT_OFS) && reg_wdata[1] && !hook_q.change
		|=> !stat_r[1])
		else $error("hook flag not cleared");
	pin_hook_a: assert property (@(posedge core_clk) disable iff (srst)
		ctrl_r[2] |=> detect_pin == $past(hook_q.steady))
		else $error("detect pin not hook state");
	rdata_idle_a: assert property (@(posedge core_clk) disable iff (srst)
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside read cycle");
	cover_press_c: cover property (@(posedge core_clk) disable iff (srst) hook_q.change && !ctrl_r[1]);
	cover_release_c: cover property (@(posedge core_clk) disable iff (srst) hook_q.change && ctrl_r[1]);
	cover_insert_c: cover property (@(posedge core_clk) disable iff (srst) mic_q.change);
	cover_remove_c: cover property (@(posedge core_clk) disable iff (srst)
		mic_q.change && ctrl_r[0]);
	cover_clear_c: cover property (@(posedge core_clk) disable iff (srst)
		reg_wr && reg_addr == `MIHD_STAT_OFS && |stat_r);
endmodule : mihd_top

/* File: bench/mihd_host.sv */
// Host model: drives the register port and polls the flags
// Assumes the register port of mihd_top on core_clk
`timescale 1ns/1ns
`include "mihd_consts.svh"
module mihd_host (
	input  wire logic        core_clk,
	output logic      [7:0]  reg_addr,
	output logic      [31:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [31:0] reg_rdata
);
	// Idle bus from time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask : wr
	// Read strobe, data taken in the cycle after
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	// Bounded polling of the status register
	task automatic poll(input int b, input int n, output logic [31:0] v);
		for (int i = 0; i < n; i++) begin
			rd(`MIHD_STAT_OFS, v);
			if (v[b] === 1'b1) break;
		end
	endtask : poll
endmodule : mihd_host

/* File: bench/test_mihd_top.sv */
// Testbench for the microphone insert and hook detector
// Assumes the design files and mihd_host compiled before it
`timescale 1ns/1ns
`include "mihd_consts.svh"
module test_mihd_top;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic        mic_cmp_in = 1'b0;
	logic        hook_cmp_in = 1'b0;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic        reg_wr, reg_rd, irq, detect_pin;
	int          miscompares = 0, num_checks = 0, cycles = 0;
	int          stat = 0, mask = 0, ctrl = 0, live = 0;
	always #5 core_clk = ~core_clk;
	mihd_top #(.SAMPLE_DIV(4), .HOOK_SAMPLES(10), .MIC_SAMPLES(10)) dut (
		.core_clk(core_clk), .srst(srst), .mic_cmp_in(mic_cmp_in),
		.hook_cmp_in(hook_cmp_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.detect_pin(detect_pin));
	mihd_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// ----
	// Checking tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	// Compares status, live state, irq and pin with the model
	task automatic check_all();
		host.rd(`MIHD_STAT_OFS, d);
		chk("status", d, stat);
		host.rd(`MIHD_LIVE_OFS, d);
		chk("live", d, live);
		chk("irq", {31'h0, irq}, ((stat & mask) != 0));
		chk("pin", {31'h0, detect_pin}, ctrl[2] ? live[1] : live[0]);
	endtask : check_all
	task automatic drv(input int b, input logic v);
		@(posedge core_clk);
		if (b == 0) mic_cmp_in <= v;
		else hook_cmp_in <= v;
	endtask : drv
	task automatic setc(input int v);
		host.wr(`MIHD_CTRL_OFS, v);
		ctrl = v;
	endtask : setc
	task automatic clr(input int b);
		host.wr(`MIHD_STAT_OFS, 1 << b);
		stat &= ~(1 << b);
	endtask : clr
	// Runs shorter than ten samples, broken by misses, never qualify
	task automatic bounce(input int b, input logic lvl);
		repeat (4) begin
			drv(b, lvl);
			repeat ($urandom_range(8, 28)) @(posedge core_clk);
			drv(b, ~lvl);
			repeat ($urandom_range(9, 16)) @(posedge core_clk);
		end
		repeat (60) @(posedge core_clk);
		check_all();
	endtask : bounce
	// Steady level: no flag early, flag within the bound
	task automatic qualify(input int b, input logic lvl);
		drv(b, lvl);
		repeat (15) begin
			host.rd(`MIHD_STAT_OFS, d);
			chk("early", d, stat);
		end
		host.poll(b, 40, d);
		stat |= 1 << b;
		live ^= 1 << b;
		chk("flag", d, stat);
		check_all();
	endtask : qualify
	// Main sequence: insert, press, release, remove
	initial begin
		void'($urandom(32'hf314));
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		host.rd(`MIHD_CTRL_OFS, d);
		chk("ctrl", d, 0);
		host.rd(8'h10, d);
		chk("unmapped", d, 0);
		check_all();
		host.wr(`MIHD_MASK_OFS, 3);
		mask = 3;
		setc(0);
		bounce(0, 1'b1);
		qualify(0, 1'b1);
		clr(0);
		setc(1);
		bounce(1, 1'b1);
		qualify(1, 1'b1);
		setc(7);
		check_all();
		mask = $urandom_range(0, 3);
		host.wr(`MIHD_MASK_OFS, mask);
		check_all();
		clr(1);
		bounce(1, 1'b0);
		qualify(1, 1'b0);
		setc(5);
		clr(1);
		qualify(0, 1'b0);
		setc(4);
		clr(0);
		check_all();
		stop_test();
	end
	// Hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			stop_test();
		end
	end
endmodule : test_mihd_top
